// file: hdl/mmhi_pkg.sv
// constants, register map and state type for the multi-mode host controller
// assumes a 50 MHz mclk and a display module wired pin for pin to the outputs
package mmhi_pkg;
  // register byte offsets on the ahb-lite bus
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_CMD    = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;

  // control register fields
  localparam int CTRL_BUS_LSB = 0;
  localparam int CTRL_COM     = 3;
  localparam int CTRL_SEG     = 4;
  localparam int CTRL_ROM_LSB = 5;
  localparam int CTRL_CNT_LSB = 7;
  localparam int CTRL_RST     = 9;
  localparam int CTRL_SA0     = 10;
  localparam int CTRL_W       = 11;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 11'h018;

  // command register fields
  localparam int CMD_DC = 8;
  localparam int CMD_RD = 9;

  // status register fields
  localparam int STS_BUSY      = 0;
  localparam int STS_OVERRUN   = 1;
  localparam int STS_REFUSED   = 2;
  localparam int STS_NACK      = 3;
  localparam int STS_RDATA_LSB = 8;

  // bus select strap codes
  localparam logic [2:0] BUS_SERIAL = 3'h0;
  localparam logic [2:0] BUS_I2C    = 3'h2;
  localparam logic [2:0] BUS_M68_8  = 3'h4;
  localparam logic [2:0] BUS_M68_4  = 3'h5;
  localparam logic [2:0] BUS_I80_8  = 3'h6;
  localparam logic [2:0] BUS_I80_4  = 3'h7;

  // i2c framing
  localparam logic [5:0] I2C_ADDR_HI_DEF = 6'h1E;
  localparam int         I2C_CTRL_DC     = 6;

  // pin phase timing
  localparam int CLK_NS    = 20;
  localparam int PHASE_NS  = 160;
  localparam int PHASE_CYC = (PHASE_NS + CLK_NS - 1) / CLK_NS;

  typedef enum logic [3:0] {
    SQ_IDLE, SQ_P_SETUP, SQ_P_STROBE, SQ_P_HOLD,
    SQ_S_FALL, SQ_S_RISE, SQ_S_END,
    SQ_I_FALL, SQ_I_RISE, SQ_I_HOLD, SQ_I_STOP1, SQ_I_STOP2, SQ_I_STOP3
  } mmhi_state_t;
endpackage

// file: hdl/mmhi_sync.sv
// two-flop synchroniser for a vector of pin inputs
// assumes the bits are independent levels; no word coherence is promised
`timescale 1ns/10ps
module mmhi_sync #(
  parameter int WIDTH = 8
)(
  input  wire logic             mclk,
  input  wire logic             sys_rst,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta;

  // first stage feeds only the second stage
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      meta     <= '0;
      sync_out <= '0;
    end
    else
    begin
      meta     <= async_in;
      sync_out <= meta;
    end
  end
endmodule

// file: hdl/mmhi_host.sv
// host-side controller driving a character display module over its pins
// assumes an ahb-lite master on the bus and the module's data pins wired to pin_data_*
//
// Contract
// - chip select held low in i2c mode
// - data_command_select held low in serial mode
// - 6800 read_write_select high read, low write
// - 6800 enable_strobe high starts transfer
// - 8080 write strobe low starts write
// - 8080 read strobe low starts read
// - strobes held low in serial and i2c
// - i2c sda on d1/d2, scl on d0
// - unused data pins driven low; d2 is released, not driven, in serial mode
// - reset_n low initialises, high in operation
//
// Added by the designer: register access over AHB-Lite and the placing of the registers.
`timescale 1ns/10ps
module mmhi_host
  import mmhi_pkg::*;
#(
  parameter int         PHASE_CYCLES = PHASE_CYC,
  parameter logic [5:0] I2C_ADDR_HI  = I2C_ADDR_HI_DEF
)(
  input  wire logic        mclk,
  input  wire logic        sys_rst,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic      [31:0] hrdata,
  output logic      [2:0]  pin_bus_select,
  output logic             pin_com_scan_dir,
  output logic             pin_seg_scan_dir,
  output logic      [1:0]  pin_char_rom_select,
  output logic      [1:0]  pin_char_count_select,
  output logic             pin_reset_n,
  output logic             pin_chip_select_n,
  output logic             pin_data_command_select,
  output logic             pin_read_write_select,
  output logic             pin_enable_strobe,
  output logic      [7:0]  pin_data_out,
  output logic      [7:0]  pin_data_oe,
  input  wire logic [7:0]  pin_data_in
);
  // refuse phase lengths the divider cannot make
  if (PHASE_CYCLES < 2 || PHASE_CYCLES > 65535)
  begin : g_phase_chk
    $error("PHASE_CYCLES must lie between 2 and 65535");
  end

  logic [15:0]       div_cnt;
  logic              tick;
  logic [7:0]        din_s;
  logic              ap_write;
  logic              ap_read;
  logic [7:0]        ap_addr;
  logic [31:0]       rd_word;
  logic [CTRL_W-1:0] ctrl;
  logic              pending;
  logic [7:0]        cmd_byte;
  logic              cmd_dc;
  logic              cmd_rd;
  logic              flag_overrun;
  logic              flag_refused;
  logic              flag_nack;
  logic [7:0]        rd_data;
  mmhi_state_t       state;
  logic [7:0]        shift;
  logic [3:0]        bit_cnt;
  logic [1:0]        byte_idx;
  logic              nib;

  wire taken    = hsel & hready & htrans[1];
  wire wr_ctrl  = ap_write && (ap_addr == REG_CTRL);
  wire wr_cmd   = ap_write && (ap_addr == REG_CMD);
  wire wr_sts   = ap_write && (ap_addr == REG_STATUS);
  wire is_ser   = pin_bus_select == BUS_SERIAL;
  wire is_i2c   = pin_bus_select == BUS_I2C;
  wire is_par   = pin_bus_select[2];
  wire is_4bit  = (pin_bus_select == BUS_M68_4) || (pin_bus_select == BUS_I80_4);
  wire is_8080  = (pin_bus_select == BUS_I80_8) || (pin_bus_select == BUS_I80_4);
  wire busy     = pending || (state != SQ_IDLE);
  wire cmd_ok   = pin_reset_n && (is_par || is_ser || is_i2c)
                  && !(hwdata[CMD_RD] && !is_par);
  wire start    = (state == SQ_IDLE) && tick && pending;
  wire nack_evt = (state == SQ_I_HOLD) && tick && (bit_cnt == 4'h8) && din_s[2];

  // bytes of one i2c write: address, control, payload
  function automatic logic [7:0] i2c_byte(input logic [1:0] idx);
    logic [7:0] b;
    b = cmd_byte;
    if (idx == 2'h0)
      b = {I2C_ADDR_HI, ctrl[CTRL_SA0], 1'b0};
    else if (idx == 2'h1)
      b = 8'(cmd_dc) << I2C_CTRL_DC;
    return b;
  endfunction

  // phase divider, one tick per pin phase
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      div_cnt <= 16'h0000;
      tick    <= 1'b0;
    end
    else if (div_cnt == 16'(PHASE_CYCLES - 1))
    begin
      div_cnt <= 16'h0000;
      tick    <= 1'b1;
    end
    else
    begin
      div_cnt <= div_cnt + 16'h0001;
      tick    <= 1'b0;
    end
  end

  // data pins come from the module's domain
  mmhi_sync #(
    .WIDTH (8)
  ) u_din_sync (
    .mclk     (mclk),
    .sys_rst  (sys_rst),
    .async_in (pin_data_in),
    .sync_out (din_s)
  );

  // read mux over own registers, unmapped reads zero
  always_comb
  begin
    rd_word = 32'h0000_0000;
    if (ap_addr == REG_CTRL)
      rd_word = 32'(ctrl);
    else if (ap_addr == REG_STATUS)
      rd_word = {16'h0000, rd_data, 4'h0, flag_nack, flag_refused, flag_overrun, busy};
  end

  // ahb-lite slave: writes zero wait, reads one wait state
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      ap_write  <= 1'b0;
      ap_read   <= 1'b0;
      ap_addr   <= 8'h00;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      hrdata    <= 32'h0000_0000;
    end
    else
    begin
      ap_write <= taken & hwrite;
      ap_read  <= taken & ~hwrite;
      if (taken)
        ap_addr <= haddr[7:0];
      if (taken && !hwrite)
        hreadyout <= 1'b0;
      else if (ap_read)
      begin
        hreadyout <= 1'b1;
        hrdata    <= rd_word;
      end
    end
  end

  // control register
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
      ctrl <= CTRL_RESET;
    else if (wr_ctrl)
      ctrl <= hwdata[CTRL_W-1:0];
  end

  // reset pin and straps; straps follow ctrl only while reset is held
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      pin_reset_n           <= 1'b0;
      pin_bus_select        <= CTRL_RESET[CTRL_BUS_LSB +: 3];
      pin_com_scan_dir      <= CTRL_RESET[CTRL_COM];
      pin_seg_scan_dir      <= CTRL_RESET[CTRL_SEG];
      pin_char_rom_select   <= CTRL_RESET[CTRL_ROM_LSB +: 2];
      pin_char_count_select <= CTRL_RESET[CTRL_CNT_LSB +: 2];
    end
    else
    begin
      pin_reset_n <= ctrl[CTRL_RST];
      if (!pin_reset_n)
      begin
        pin_bus_select        <= ctrl[CTRL_BUS_LSB +: 3];
        pin_com_scan_dir      <= ctrl[CTRL_COM];
        pin_seg_scan_dir      <= ctrl[CTRL_SEG];
        pin_char_rom_select   <= ctrl[CTRL_ROM_LSB +: 2];
        pin_char_count_select <= ctrl[CTRL_CNT_LSB +: 2];
      end
    end
  end

  // command latch, accepted only when idle and the mode can serve it
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      pending  <= 1'b0;
      cmd_byte <= 8'h00;
      cmd_dc   <= 1'b0;
      cmd_rd   <= 1'b0;
    end
    else if (wr_cmd && !busy && cmd_ok)
    begin
      pending  <= 1'b1;
      cmd_byte <= hwdata[7:0];
      cmd_dc   <= hwdata[CMD_DC];
      cmd_rd   <= hwdata[CMD_RD];
    end
    else if (start)
      pending <= 1'b0;
  end

  // sticky flags, write one to clear, a new event wins over the clear
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      flag_overrun <= 1'b0;
      flag_refused <= 1'b0;
      flag_nack    <= 1'b0;
    end
    else
    begin
      if (wr_cmd && busy)
        flag_overrun <= 1'b1;
      else if (wr_sts && hwdata[STS_OVERRUN])
        flag_overrun <= 1'b0;
      if (wr_cmd && !busy && !cmd_ok)
        flag_refused <= 1'b1;
      else if (wr_sts && hwdata[STS_REFUSED])
        flag_refused <= 1'b0;
      if (nack_evt)
        flag_nack <= 1'b1;
      else if (wr_sts && hwdata[STS_NACK])
        flag_nack <= 1'b0;
    end
  end

  // pin sequencer; every state advances on a phase tick
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      state                   <= SQ_IDLE;
      shift                   <= 8'h00;
      bit_cnt                 <= 4'h0;
      byte_idx                <= 2'h0;
      nib                     <= 1'b0;
      rd_data                 <= 8'h00;
      pin_chip_select_n       <= 1'b1;
      pin_data_command_select <= 1'b0;
      pin_read_write_select   <= 1'b0;
      pin_enable_strobe       <= 1'b0;
      pin_data_out            <= 8'h00;
      pin_data_oe             <= 8'hFF;
    end
    else
    begin
      case (state)
        SQ_IDLE:
        begin
          pin_chip_select_n       <= ~is_i2c;
          pin_data_command_select <= is_i2c & ctrl[CTRL_SA0];
          pin_read_write_select   <= is_8080;
          pin_enable_strobe       <= is_8080;
          pin_data_out            <= (is_ser || is_i2c) ? 8'h01 : 8'h00;
          pin_data_oe             <= is_i2c ? 8'hF9 : (is_ser ? 8'hFB : 8'hFF);
          if (start && is_par)
          begin
            pin_chip_select_n       <= 1'b0;
            pin_data_command_select <= cmd_dc;
            if (!is_8080)
              pin_read_write_select <= cmd_rd;
            nib <= 1'b0;
            if (is_4bit)
            begin
              pin_data_out <= {cmd_byte[7:4], 4'h0};
              pin_data_oe  <= cmd_rd ? 8'h0F : 8'hFF;
            end
            else
            begin
              pin_data_out <= cmd_byte;
              pin_data_oe  <= cmd_rd ? 8'h00 : 8'hFF;
            end
            state <= SQ_P_SETUP;
          end
          else if (start && is_ser)
          begin
            pin_chip_select_n <= 1'b0;
            shift             <= cmd_byte;
            bit_cnt           <= 4'h0;
            state             <= SQ_S_FALL;
          end
          else if (start && is_i2c)
          begin
            pin_data_oe[1] <= 1'b1;  // start: sda falls while scl high
            shift          <= i2c_byte(2'h0);
            byte_idx       <= 2'h0;
            bit_cnt        <= 4'h0;
            state          <= SQ_I_FALL;
          end
        end
        SQ_P_SETUP:
          if (tick)
          begin
            if (!is_8080)
              pin_enable_strobe <= 1'b1;
            else if (cmd_rd)
              pin_enable_strobe <= 1'b0;
            else
              pin_read_write_select <= 1'b0;
            state <= SQ_P_STROBE;
          end
        SQ_P_STROBE:
          if (tick)
          begin
            // capture just before the strobe ends
            if (!is_4bit)
              rd_data <= din_s;
            else if (!nib)
              rd_data[7:4] <= din_s[7:4];
            else
              rd_data[3:0] <= din_s[7:4];
            pin_enable_strobe     <= is_8080;
            pin_read_write_select <= is_8080 ? 1'b1 : cmd_rd;
            state                 <= SQ_P_HOLD;
          end
        SQ_P_HOLD:
          if (tick)
          begin
            if (is_4bit && !nib)
            begin
              nib          <= 1'b1;
              pin_data_out <= {cmd_byte[3:0], 4'h0};
              state        <= SQ_P_SETUP;
            end
            else
            begin
              pin_chip_select_n <= 1'b1;
              state             <= SQ_IDLE;
            end
          end
        SQ_S_FALL:
          if (tick)
          begin
            pin_data_out[0] <= 1'b0;
            pin_data_out[1] <= shift[7];
            state           <= SQ_S_RISE;
          end
        SQ_S_RISE:
          if (tick)
          begin
            pin_data_out[0] <= 1'b1;
            shift           <= {shift[6:0], 1'b0};
            bit_cnt         <= bit_cnt + 4'h1;
            state           <= (bit_cnt == 4'h7) ? SQ_S_END : SQ_S_FALL;
          end
        SQ_S_END:
          if (tick)
          begin
            pin_chip_select_n <= 1'b1;
            state             <= SQ_IDLE;
          end
        SQ_I_FALL:
          if (tick)
          begin
            pin_data_out[0] <= 1'b0;
            pin_data_oe[1]  <= (bit_cnt == 4'h8) ? 1'b0 : ~shift[7];
            state           <= SQ_I_RISE;
          end
        SQ_I_RISE:
          if (tick)
          begin
            pin_data_out[0] <= 1'b1;
            state           <= SQ_I_HOLD;
          end
        SQ_I_HOLD:
          if (tick)
          begin
            if (bit_cnt != 4'h8)
            begin
              shift   <= {shift[6:0], 1'b0};
              bit_cnt <= bit_cnt + 4'h1;
              state   <= SQ_I_FALL;
            end
            else if (byte_idx == 2'h2)
              state <= SQ_I_STOP1;
            else
            begin
              byte_idx <= byte_idx + 2'h1;
              shift    <= i2c_byte(byte_idx + 2'h1);
              bit_cnt  <= 4'h0;
              state    <= SQ_I_FALL;
            end
          end
        SQ_I_STOP1:
          if (tick)
          begin
            pin_data_out[0] <= 1'b0;
            pin_data_oe[1]  <= 1'b1;
            state           <= SQ_I_STOP2;
          end
        SQ_I_STOP2:
          if (tick)
          begin
            pin_data_out[0] <= 1'b1;
            state           <= SQ_I_STOP3;
          end
        SQ_I_STOP3:
          if (tick)
          begin
            pin_data_oe[1] <= 1'b0;  // stop: sda rises while scl high
            state          <= SQ_IDLE;
          end
        default:
          state <= SQ_IDLE;
      endcase
    end
  end
endmodule

// file: testbench/mmhi_host_asserts.sv
// port checker for the multi-mode host controller
// assumes it is bound into mmhi_host; pin checks start once reset_n is out
`timescale 1ns/10ps
module mmhi_host_asserts
  import mmhi_pkg::*;
#(
  parameter int PHASE_CYCLES = PHASE_CYC
)(
  input wire logic       mclk,
  input wire logic       sys_rst,
  input wire logic       hsel,
  input wire logic [1:0] htrans,
  input wire logic       hwrite,
  input wire logic       hready,
  input wire logic       hreadyout,
  input wire logic [2:0] pin_bus_select,
  input wire logic       pin_reset_n,
  input wire logic       pin_chip_select_n,
  input wire logic       pin_data_command_select,
  input wire logic       pin_read_write_select,
  input wire logic       pin_enable_strobe
);
  logic       run_d;
  logic       run;
  logic       req;
  logic [7:0] wr_cnt;
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  // run: straps frozen for a cycle, idle drive settled
  always_ff @(posedge mclk or posedge sys_rst)
    if (sys_rst)
      run_d <= 1'b0;
    else
      run_d <= pin_reset_n;
  // cycles the write strobe has been low
  always_ff @(posedge mclk or posedge sys_rst)
    if (sys_rst)
      wr_cnt <= 8'h0;
    else
      wr_cnt <= pin_read_write_select ? 8'h0 : wr_cnt + 8'h1;
  assign run = run_d & pin_reset_n;
  assign req = hsel & hready & htrans[1];
  rd_wait_a: assert property (req && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read data phase length wrong");
  wr_nowait_a: assert property (req && hwrite |=> hreadyout)
    else $error("write data phase stalled");
  straps_fixed_a: assert property (run |-> $stable(pin_bus_select))
    else $error("strap moved after reset release");
  i2c_cs_low_a: assert property (run && pin_bus_select == BUS_I2C |-> !pin_chip_select_n)
    else $error("chip select high in i2c");
  quiet_strobes_a: assert property (run && !pin_bus_select[2] |->
    !pin_read_write_select && !pin_enable_strobe) else $error("strobe active in serial mode");
  serial_dc_a: assert property (run && pin_bus_select == BUS_SERIAL |-> !pin_data_command_select)
    else $error("dc high in serial");
  strobe_sel_a: assert property (run && pin_bus_select[2] && (pin_bus_select[1] ?
    !(pin_read_write_select && pin_enable_strobe) : pin_enable_strobe) |-> !pin_chip_select_n)
    else $error("strobe without chip select");
  wr_width_a: assert property (run && pin_bus_select[2:1] == 2'b11 &&
    $rose(pin_read_write_select) |-> wr_cnt == PHASE_CYCLES) else $error("write strobe width");
  e_rw_hold_a: assert property (run && pin_bus_select[2:1] == 2'b10 && pin_enable_strobe &&
    $past(pin_enable_strobe) |-> $stable(pin_read_write_select)) else $error("r/w moved under e");
  cover property (req && !hwrite);
  cover property (run && pin_bus_select == BUS_I80_4 && $rose(pin_enable_strobe));
  cover property (run && pin_bus_select == BUS_SERIAL && !pin_chip_select_n);
endmodule

// file: testbench/mmhi_dev_model.sv
// display module pin model: reports written bytes, answers reads, acks i2c
// assumes registered host pins; d1 and d2 joined as one pulled-up sda line
`timescale 1ns/10ps
module mmhi_dev_model
  import mmhi_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic [2:0] bus_sel,
  input  wire logic       rst_n,
  input  wire logic       cs_n,
  input  wire logic       dc,
  input  wire logic       rw,
  input  wire logic       en,
  input  wire logic [7:0] dout,
  input  wire logic [7:0] doe,
  input  wire logic [7:0] rd_byte,
  output logic      [7:0] din,
  output logic            got,
  output logic      [8:0] got_word
);
  logic       pen, prw, pscl, psda, nib, ack, sda, rdg;
  logic [3:0] cnt;
  logic [7:0] sh, last, drv;
  // open drain sda, host or ack pulls low
  assign sda = ~((doe[1] & ~dout[1]) | ack);
  // read window, else released lines toggle
  assign rdg = ~cs_n & (bus_sel[1] ? ~en : en & rw);
  assign drv = !rdg ? ~last : !bus_sel[0] ? rd_byte : {nib ? rd_byte[3:0] : rd_byte[7:4], 4'h0};
  assign din = bus_sel == BUS_I2C ? {5'h0, sda, sda, dout[0]} : (doe & dout) | (~doe & drv);
  // bus decoding per strap mode
  always @(posedge mclk)
  begin
    got <= 1'b0;
    last <= din;
    prw <= rw;
    pen <= en;
    pscl <= din[0];
    psda <= sda;
    if (!rst_n || (cs_n && bus_sel != BUS_I2C))
    begin
      nib <= 1'b0;
      cnt <= 4'h0;
      ack <= 1'b0;
    end
    else if (bus_sel[2])
    begin
      if (bus_sel[1] ? rw & !prw : !en & pen & !rw)
      begin
        sh[3:0] <= dout[7:4];
        got <= !bus_sel[0] | nib;
        got_word <= {dc, bus_sel[0] ? {sh[3:0], dout[7:4]} : dout};
        nib <= bus_sel[0] & ~nib;
      end
      if (bus_sel[1] ? en & !pen : !en & pen & rw)
        nib <= bus_sel[0] & ~nib;
    end
    else if (bus_sel == BUS_SERIAL && din[0] && !pscl)
    begin
      sh <= {sh[6:0], dout[1]};
      cnt <= cnt + 4'h1;
      got <= cnt == 4'h7;
      got_word <= {1'b0, sh[6:0], dout[1]};
    end
    else if (bus_sel == BUS_I2C)
    begin
      if (pscl && din[0] && psda && !sda)
        cnt <= 4'h0;
      else if (din[0] && !pscl)
      begin
        sh <= {sh[6:0], sda};
        cnt <= cnt == 4'h8 ? 4'h0 : cnt + 4'h1;
        got <= cnt == 4'h7;
        got_word <= {1'b0, sh[6:0], sda};
      end
      if (!din[0] && pscl)
        ack <= cnt == 4'h8;
    end
  end
endmodule

// file: testbench/mmhi_host_tb_top.sv
// bench for the host controller driving the display pin model
// assumes ahb-lite single word transfers and default phase timing
`timescale 1ns/10ps
module mmhi_host_tb_top
  import mmhi_pkg::*;
;
  localparam logic [2:0] MODES [6] = '{BUS_I80_8, BUS_M68_4, BUS_SERIAL, BUS_I80_4,
                                       BUS_M68_8, BUS_I2C};
  logic        mclk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        hwrite = 1'b0;
  logic [1:0]  htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata, rv;
  logic        hreadyout, hresp, rst_n, cs_n, dc, rw, en, com, seg, got;
  logic [2:0]  bsel;
  logic [1:0]  rom, cnt;
  logic [7:0]  dout, doe, din;
  logic [7:0]  rd_b = 8'h0;
  logic [8:0]  got_w;
  logic [31:0] seed = 32'h42;
  logic [8:0]  exp_q[$];
  int          num_errors = 0;
  int          n_compared = 0;
  always #10 mclk = ~mclk;
  mmhi_host uut (.mclk(mclk), .sys_rst(sys_rst), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .pin_bus_select(bsel), .pin_com_scan_dir(com),
    .pin_seg_scan_dir(seg), .pin_char_rom_select(rom), .pin_char_count_select(cnt),
    .pin_reset_n(rst_n), .pin_chip_select_n(cs_n), .pin_data_command_select(dc),
    .pin_read_write_select(rw), .pin_enable_strobe(en), .pin_data_out(dout),
    .pin_data_oe(doe), .pin_data_in(din));
  mmhi_dev_model dev (.mclk(mclk), .bus_sel(bsel), .rst_n(rst_n), .cs_n(cs_n), .dc(dc),
    .rw(rw), .en(en), .dout(dout), .doe(doe), .rd_byte(rd_b), .din(din), .got(got),
    .got_word(got_w));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // one single-word transfer, read data left in rv
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    haddr <= {24'h0, a};
    hwrite <= wr;
    htrans <= 2'h2;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    rv = hrdata;
  endtask
  // poll status until the pin sequencer is idle
  task automatic idle();
    rv = 32'h1;
    for (int i = 0; i < 500 && rv[STS_BUSY] !== 1'b0; i++)
      ahb(1'b0, REG_STATUS, 32'h0);
    // a poll that runs out counts as a mismatch
    check("idle", rv[STS_BUSY], 1'b0);
  endtask
  // set straps, release, write a byte, read back in parallel modes
  task automatic run_mode(input logic [2:0] m);
    logic [31:0] r;
    logic [10:0] c;
    r = rnd();
    c = {r[10], 1'b0, r[8:3], m};
    ahb(1'b1, REG_CTRL, {21'h0, c});
    ahb(1'b1, REG_CTRL, {21'h0, c | 11'h200});
    repeat (2) @(posedge mclk);
    check("straps", {bsel, cnt, rom, seg, com}, {m, c[8:3]});
    if (m == BUS_I2C)
    begin
      check("address bit", dc, r[10]);
      exp_q.push_back({1'b0, I2C_ADDR_HI_DEF, r[10], 1'b0});
      exp_q.push_back({2'h0, r[11], 6'h0});
    end
    exp_q.push_back({m[2] & r[11], r[23:16]});
    ahb(1'b1, REG_CMD, {23'h0, r[11], r[23:16]});
    idle();
    check("nack", rv[STS_NACK], 1'b0);
    if (m[2])
    begin
      rd_b <= r[31:24];
      ahb(1'b1, REG_CMD, 32'h300);
      idle();
      check("read byte", rv[15:8], rd_b);
    end
  endtask
  task automatic conclude();
    $display("compared %0d errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // compare each byte the model reports with the oldest note
  always @(posedge mclk)
    if (got === 1'b1)
    begin
      if (exp_q.size() == 0)
        check("spare byte", {23'h0, got_w}, 32'hFFFFFFFF);
      else
        check("byte", {23'h0, got_w}, {23'h0, exp_q.pop_front()});
    end
  // main sequence
  initial
  begin
    repeat (5) @(posedge mclk);
    sys_rst <= 1'b0;
    ahb(1'b0, REG_CTRL, 32'h0);
    check("ctrl reset", rv, {21'h0, CTRL_RESET});
    check("reset pin", rst_n, 1'b0);
    for (int k = 0; k < 6; k++)
      run_mode(MODES[k]);
    // i2c with address bit 0: gpio setup command, second write while busy dropped
    ahb(1'b1, REG_CTRL, 32'h2);
    ahb(1'b1, REG_CTRL, 32'h202);
    exp_q.push_back({1'b0, I2C_ADDR_HI_DEF, 2'h0});
    exp_q.push_back(9'h000);
    exp_q.push_back(9'h0DC);
    ahb(1'b1, REG_CMD, 32'hDC);
    ahb(1'b1, REG_CMD, 32'h1FF);
    idle();
    check("overrun", rv[STS_OVERRUN], 1'b1);
    ahb(1'b1, REG_STATUS, 32'h2);
    ahb(1'b0, REG_STATUS, 32'h0);
    check("overrun clear", rv[STS_OVERRUN], 1'b0);
    check("hresp", hresp, 1'b0);
    ahb(1'b1, REG_CTRL, 32'h1);
    ahb(1'b1, REG_CTRL, 32'h201);
    ahb(1'b1, REG_CMD, 32'h55);
    ahb(1'b0, REG_STATUS, 32'h0);
    check("refused", rv[STS_REFUSED], 1'b1);
    ahb(1'b0, 8'h0C, 32'h0);
    check("unmapped", rv, 32'h0);
    check("left over", 32'(exp_q.size()), 32'h0);
    conclude();
  end
  // watchdog
  initial
  begin
    #400000;
    num_errors++;
    conclude();
  end
endmodule
bind mmhi_host mmhi_host_asserts #(.PHASE_CYCLES(PHASE_CYCLES)) chk (.mclk(mclk),
  .sys_rst(sys_rst), .hsel(hsel), .htrans(htrans), .hwrite(hwrite), .hready(hready),
  .hreadyout(hreadyout), .pin_bus_select(pin_bus_select), .pin_reset_n(pin_reset_n),
  .pin_chip_select_n(pin_chip_select_n), .pin_data_command_select(pin_data_command_select),
  .pin_read_write_select(pin_read_write_select), .pin_enable_strobe(pin_enable_strobe));
